// ### rtl/timer_pkg.sv
/*
  constants, register map and decode tables for the two-channel timer.
  assumes a single 40 MHz clock and an apb master on the register side.
*/
// Contract
// (RULE1) fast enable clear: trigger to output activation takes five clocks
// (RULE2) fast enable set: trigger edge acts as compare match, three clocks
// (RULE3) fast enable acts only in the two pwm output modes
// (RULE4) ch1 direction: 00 out, 01 input one, 10 input two, 11 trigger
// (RULE5) ch2 direction: 00 out, 01 input two, 10 input one, 11 trigger
// (RULE6) direction field writable only while the channel enable is 0
// (RULE7) filter passes a new level after N agreeing consecutive samples
// (RULE8) filter code picks sampling rate and N from the fixed table
// (RULE9) capture divider: capture every 1, 2, 4 or 8 detected edges
// (RULE10) capture divider count held at zero while channel enable is 0
// (RULE11) output polarity 0 active high, 1 active low; ch2 mirrors ch1
// (RULE12) software keeps complement polarity clear on output channels
// (RULE13) input polarity pair: 00 rising, 01 falling, 11 both edges
// (RULE14) software never uses pair 10, nor 11 in encoder mode
// (RULE15) enable 0: output and drive enable low; 1: reference plus polarity
// (RULE16) input channel: enable gates capture into the compare register
// (RULE17) counter value is a 16-bit read/write register
// (RULE18) counter rate is divider input rate over divider value plus one
// (RULE19) divider value takes effect only at an update event
// (RULE20) counter stays still while reload value is zero
// (RULE21) compare value: direct without preload, else copied at update
// (RULE22) input channel register holds counter of latest capture
// (RULE23) pwm1 active while counter below compare; pwm2 the inverse
// (RULE24) force update clears counter and divider count, loads preloads
package timer_pkg;

  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h18;
  localparam logic [7:0] OFF_ENABLE = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  localparam logic [7:0] OFF_DIVIDER = 8'h28;
  localparam logic [7:0] OFF_RELOAD = 8'h2C;
  localparam logic [7:0] OFF_CMP1 = 8'h34;
  localparam logic [7:0] OFF_CMP2 = 8'h38;

  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] ENABLE_MASK = 16'h00BB;

  // control register bits
  localparam int CTRL_COUNT_EN = 0;
  localparam int CTRL_FORCE_UPDATE = 1;
  localparam int CTRL_ITRIG_SEL = 2;
  localparam int CTRL_TRIG_RESET = 3;
  localparam int CTRL_WIDTH = 4;

  // per-channel field positions, channel base is ch * stride
  localparam int MODE_STRIDE = 8;
  localparam int MODE_DIR = 0;
  localparam int MODE_FAST = 2;
  localparam int MODE_PRELOAD = 3;
  localparam int MODE_OUT = 4;
  localparam int MODE_CAPDIV = 2;
  localparam int MODE_FILTER = 4;
  localparam int ENABLE_STRIDE = 4;
  localparam int ENABLE_ON = 0;
  localparam int ENABLE_POL = 1;
  localparam int ENABLE_NPOL = 3;

  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_OWN = 2'h1;
  localparam logic [1:0] DIR_OTHER = 2'h2;
  localparam logic [1:0] DIR_TRIGGER = 2'h3;

  localparam logic [2:0] OCM_FROZEN = 3'h0;
  localparam logic [2:0] OCM_SET = 3'h1;
  localparam logic [2:0] OCM_CLEAR = 3'h2;
  localparam logic [2:0] OCM_TOGGLE = 3'h3;
  localparam logic [2:0] OCM_LOW = 3'h4;
  localparam logic [2:0] OCM_HIGH = 3'h5;
  localparam logic [2:0] OCM_PWM1 = 3'h6;
  localparam logic [2:0] OCM_PWM2 = 3'h7;

  // sampling divider as a power of two, codes 0 to 3 sample on every clock
  function automatic logic [2:0] filter_div_log2(input logic [3:0] code);
    case (code)
      4'h4, 4'h5: filter_div_log2 = 3'h1;
      4'h6, 4'h7: filter_div_log2 = 3'h2;
      4'h8, 4'h9: filter_div_log2 = 3'h3;
      4'hA, 4'hB, 4'hC: filter_div_log2 = 3'h4;
      4'hD, 4'hE, 4'hF: filter_div_log2 = 3'h5;
      default: filter_div_log2 = 3'h0;
    endcase
  endfunction : filter_div_log2

  function automatic logic [3:0] filter_len(input logic [3:0] code);
    case (code)
      4'h1: filter_len = 4'h2;
      4'h2: filter_len = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hB, 4'hE: filter_len = 4'h6;
      4'hA, 4'hD: filter_len = 4'h5;
      4'h0: filter_len = 4'h1;
      default: filter_len = 4'h8;
    endcase
  endfunction : filter_len

endpackage : timer_pkg

// ### rtl/input_filter.sv
/*
  digital glitch filter for one timer input.
  assumes the sample input is already synchronised to pclk.
*/
module input_filter
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample,
  input wire logic [3:0] code,
  output logic filtered
);

  logic [4:0] div_cnt;
  logic [3:0] agree;
  logic [4:0] next_div_cnt;
  logic [3:0] next_agree;
  logic next_filtered;
  logic [4:0] div_last;
  logic [3:0] len;
  logic tick;

  always_comb
  begin
    div_last = 5'((6'h01 << filter_div_log2(code)) - 6'h01); // [RULE8]
    len = filter_len(code);
    tick = (div_cnt >= div_last);
    next_div_cnt = tick ? 5'h00 : 5'(div_cnt + 5'h01);
    next_agree = agree;
    next_filtered = filtered;
    if (tick)
    begin
      // any disagreeing sample restarts the run
      if (sample == filtered)
        next_agree = 4'h0;
      else if (4'(agree + 4'h1) >= len)
      begin
        next_filtered = sample; // [RULE7]
        next_agree = 4'h0;
      end
      else
        next_agree = 4'(agree + 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 5'h00;
      agree <= 4'h0;
      filtered <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      agree <= next_agree;
      filtered <= next_filtered;
    end
  end

endmodule : input_filter

// ### rtl/timer_capture_compare.sv
/*
  two-channel 16-bit timer with capture, compare and pwm, apb register slave.
  assumes timer pins and trigger arrive asynchronously; apb runs on pclk.
*/
module timer_capture_compare
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_one,
  input wire logic timer_input_two,
  input wire logic internal_trigger_source,
  output logic ch1_output,
  output logic ch2_output,
  output logic ch1_output_drive_enable,
  output logic ch2_output_drive_enable
);

  // pin synchronisers
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic trig_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      trig_prev <= 1'b0;
    end
    else
    begin
      sync_a <= {internal_trigger_source, timer_input_two, timer_input_one};
      sync_b <= sync_a;
      trig_prev <= sync_b[2];
    end
  end

  logic [1:0] filt;
  logic [15:0] mode;

  input_filter u_filter_one (
    .pclk(pclk),
    .presetn(presetn),
    .sample(sync_b[0]),
    .code(mode[MODE_FILTER +: 4]),
    .filtered(filt[0])
  );

  input_filter u_filter_two (
    .pclk(pclk),
    .presetn(presetn),
    .sample(sync_b[1]),
    .code(mode[MODE_STRIDE + MODE_FILTER +: 4]),
    .filtered(filt[1])
  );

  // register state
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [15:0] enable;
  logic [15:0] count_value;
  logic [15:0] divider_value;
  logic [15:0] divider_active;
  logic [15:0] div_count;
  logic [15:0] reload_value;
  logic [15:0] cmp_pre [2];
  logic [15:0] cmp_act [2];
  logic [2:0] cap_cnt [2];
  logic [1:0] src_prev;
  logic [1:0] ref_q;
  logic [1:0] out_q;
  logic [1:0] fast_hit;
  logic [1:0] match_q;
  logic [1:0] below_q;

  logic [CTRL_WIDTH-1:0] next_ctrl;
  logic [15:0] next_mode;
  logic [15:0] next_enable;
  logic [15:0] next_count_value;
  logic [15:0] next_divider_value;
  logic [15:0] next_divider_active;
  logic [15:0] next_div_count;
  logic [15:0] next_reload_value;
  logic [15:0] next_cmp_pre [2];
  logic [15:0] next_cmp_act [2];
  logic [2:0] next_cap_cnt [2];
  logic [1:0] next_src_prev;
  logic [1:0] next_ref;
  logic [1:0] next_out;
  logic [1:0] next_fast_hit;
  logic [1:0] next_match;
  logic [1:0] next_below;
  logic [31:0] next_prdata;

  logic wr;
  logic addr_hit;
  logic force_upd;
  logic trig_edge;
  logic running;
  logic tick;
  logic update;
  logic [31:0] rd_mux;
  logic [1:0] dir;
  logic [2:0] ocm;
  logic [1:0] src;
  logic [1:0] edge_ev;
  logic [2:0] cap_last;
  logic pol;
  logic npol;
  logic on;

  assign pready = 1'b1;

  always_comb
  begin
    case (paddr)
      OFF_CONTROL, OFF_STATUS, OFF_MODE, OFF_ENABLE, OFF_COUNT,
      OFF_DIVIDER, OFF_RELOAD, OFF_CMP1, OFF_CMP2: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
    pslverr = psel & penable & ~addr_hit;
    wr = psel & penable & pwrite & addr_hit;
    case (paddr)
      OFF_CONTROL: rd_mux = 32'(ctrl);
      OFF_STATUS: rd_mux = 32'({fast_hit, ref_q, filt});
      OFF_MODE: rd_mux = 32'(mode);
      OFF_ENABLE: rd_mux = 32'(enable);
      OFF_COUNT: rd_mux = 32'(count_value);
      OFF_DIVIDER: rd_mux = 32'(divider_value);
      OFF_RELOAD: rd_mux = 32'(reload_value);
      OFF_CMP1: rd_mux = 32'(cmp_pre[0]);
      OFF_CMP2: rd_mux = 32'(cmp_pre[1]);
      default: rd_mux = 32'h0000_0000;
    endcase
    // sampled in the setup phase so read data comes from a flop
    next_prdata = (psel & ~penable & ~pwrite) ? rd_mux : prdata;
  end

  // counter and time base
  always_comb
  begin
    force_upd = wr && paddr == OFF_CONTROL && pwdata[CTRL_FORCE_UPDATE];
    trig_edge = sync_b[2] & ~trig_prev;
    running = ctrl[CTRL_COUNT_EN] && reload_value != 16'h0000; // [RULE20]
    tick = running && div_count >= divider_active; // [RULE18]
    update = (tick && count_value >= reload_value) || force_upd
      || (trig_edge && ctrl[CTRL_TRIG_RESET]);
    next_ctrl = ctrl;
    if (wr && paddr == OFF_CONTROL)
    begin
      next_ctrl = pwdata[CTRL_WIDTH-1:0];
      next_ctrl[CTRL_FORCE_UPDATE] = 1'b0;
    end
    next_divider_value = (wr && paddr == OFF_DIVIDER) ? pwdata[15:0] : divider_value;
    next_reload_value = (wr && paddr == OFF_RELOAD) ? pwdata[15:0] : reload_value;
    next_divider_active = update ? divider_value : divider_active; // [RULE19]
    next_div_count = div_count;
    next_count_value = count_value;
    if (update && !(tick && count_value >= reload_value))
    begin
      next_div_count = 16'h0000; // [RULE24]
      next_count_value = 16'h0000;
    end
    else
    begin
      if (running)
        next_div_count = tick ? 16'h0000 : 16'(div_count + 16'h0001);
      if (wr && paddr == OFF_COUNT)
        next_count_value = pwdata[15:0]; // [RULE17]
      else if (tick)
        next_count_value = update ? 16'h0000 : 16'(count_value + 16'h0001);
    end
  end

  // channel configuration, capture and compare
  always_comb
  begin
    next_mode = mode;
    next_enable = enable;
    if (wr && paddr == OFF_ENABLE)
      next_enable = pwdata[15:0] & ENABLE_MASK;
    if (wr && paddr == OFF_MODE)
    begin
      next_mode = pwdata[15:0];
      // direction is frozen while the channel is on
      if (enable[ENABLE_ON])
        next_mode[MODE_DIR +: 2] = mode[MODE_DIR +: 2]; // [RULE6]
      if (enable[ENABLE_STRIDE + ENABLE_ON])
        next_mode[MODE_STRIDE + MODE_DIR +: 2] = mode[MODE_STRIDE + MODE_DIR +: 2];
    end
    next_cmp_pre[0] = (wr && paddr == OFF_CMP1) ? pwdata[15:0] : cmp_pre[0];
    next_cmp_pre[1] = (wr && paddr == OFF_CMP2) ? pwdata[15:0] : cmp_pre[1];
    next_src_prev = src_prev;
    next_ref = ref_q;
    next_out = out_q;
    next_fast_hit = fast_hit;
    next_match = match_q;
    next_below = below_q;
    src = 2'b00;
    edge_ev = 2'b00;
    dir = DIR_OUTPUT;
    ocm = OCM_FROZEN;
    cap_last = 3'h0;
    pol = 1'b0;
    npol = 1'b0;
    on = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      next_cap_cnt[i] = cap_cnt[i];
      dir = mode[i*MODE_STRIDE + MODE_DIR +: 2];
      ocm = mode[i*MODE_STRIDE + MODE_OUT +: 3];
      on = enable[i*ENABLE_STRIDE + ENABLE_ON];
      pol = enable[i*ENABLE_STRIDE + ENABLE_POL];
      npol = enable[i*ENABLE_STRIDE + ENABLE_NPOL];
      case (dir) // [RULE4] [RULE5]
        DIR_OWN: src[i] = filt[i];
        DIR_OTHER: src[i] = filt[1-i];
        DIR_TRIGGER: src[i] = ctrl[CTRL_ITRIG_SEL] & sync_b[2];
        default: src[i] = 1'b0;
      endcase
      next_src_prev[i] = src[i];
      // pair 10 is reserved and falls back to rising edge
      if (pol && npol)
        edge_ev[i] = src[i] ^ src_prev[i]; // [RULE13]
      else if (pol)
        edge_ev[i] = ~src[i] & src_prev[i];
      else
        edge_ev[i] = src[i] & ~src_prev[i];
      cap_last = 3'((4'h1 << mode[i*MODE_STRIDE + MODE_CAPDIV +: 2]) - 4'h1);
      next_cmp_act[i] = cmp_act[i];
      if (dir != DIR_OUTPUT)
      begin
        if (!on)
          next_cap_cnt[i] = 3'h0; // [RULE10]
        else if (edge_ev[i])
        begin
          if (cap_cnt[i] >= cap_last) // [RULE9]
          begin
            next_cap_cnt[i] = 3'h0;
            // capture wins over a same-cycle register write
            next_cmp_pre[i] = count_value; // [RULE16] [RULE22]
          end
          else
            next_cap_cnt[i] = 3'(cap_cnt[i] + 3'h1);
        end
        next_ref[i] = 1'b0;
        next_fast_hit[i] = 1'b0;
        next_out[i] = 1'b0;
      end
      else
      begin
        next_cap_cnt[i] = 3'h0;
        if (!mode[i*MODE_STRIDE + MODE_PRELOAD])
          next_cmp_act[i] = next_cmp_pre[i]; // [RULE21]
        else if (update)
          next_cmp_act[i] = cmp_pre[i];
        // compare pipeline stage gives the normal trigger path its length
        next_match[i] = (count_value == cmp_act[i]); // [RULE1]
        next_below[i] = (count_value < cmp_act[i]);
        if (update)
          next_fast_hit[i] = 1'b0;
        if (mode[i*MODE_STRIDE + MODE_FAST] && trig_edge
          && (ocm == OCM_PWM1 || ocm == OCM_PWM2)) // [RULE3]
          next_fast_hit[i] = 1'b1;
        case (ocm)
          OCM_SET: next_ref[i] = match_q[i] | ref_q[i];
          OCM_CLEAR: next_ref[i] = ~match_q[i] & ref_q[i];
          OCM_TOGGLE: next_ref[i] = match_q[i] ^ ref_q[i];
          OCM_LOW: next_ref[i] = 1'b0;
          OCM_HIGH: next_ref[i] = 1'b1;
          OCM_PWM1: next_ref[i] = below_q[i]; // [RULE23]
          OCM_PWM2: next_ref[i] = ~below_q[i];
          default: next_ref[i] = ref_q[i];
        endcase
        // fast path skips the compare stage: level reached past compare
        if (next_fast_hit[i] && (ocm == OCM_PWM1 || ocm == OCM_PWM2))
          next_ref[i] = (ocm == OCM_PWM2); // [RULE2]
        next_out[i] = on & (next_ref[i] ^ pol); // [RULE11] [RULE15]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      ctrl <= '0;
      mode <= RESET_VALUE;
      enable <= RESET_VALUE;
      count_value <= RESET_VALUE;
      divider_value <= RESET_VALUE;
      divider_active <= RESET_VALUE;
      div_count <= RESET_VALUE;
      reload_value <= RESET_VALUE;
      cmp_pre[0] <= RESET_VALUE;
      cmp_pre[1] <= RESET_VALUE;
      cmp_act[0] <= RESET_VALUE;
      cmp_act[1] <= RESET_VALUE;
      cap_cnt[0] <= 3'h0;
      cap_cnt[1] <= 3'h0;
      src_prev <= 2'b00;
      ref_q <= 2'b00;
      out_q <= 2'b00;
      fast_hit <= 2'b00;
      match_q <= 2'b00;
      below_q <= 2'b00;
    end
    else
    begin
      prdata <= next_prdata;
      ctrl <= next_ctrl;
      mode <= next_mode;
      enable <= next_enable;
      count_value <= next_count_value;
      divider_value <= next_divider_value;
      divider_active <= next_divider_active;
      div_count <= next_div_count;
      reload_value <= next_reload_value;
      cmp_pre <= next_cmp_pre;
      cmp_act <= next_cmp_act;
      cap_cnt <= next_cap_cnt;
      src_prev <= next_src_prev;
      ref_q <= next_ref;
      out_q <= next_out;
      fast_hit <= next_fast_hit;
      match_q <= next_match;
      below_q <= next_below;
    end
  end

  // drive enable follows the channel enable bit only in output direction
  assign ch1_output = out_q[0];
  assign ch2_output = out_q[1];
  assign ch1_output_drive_enable = enable[ENABLE_ON]
    & (mode[MODE_DIR +: 2] == DIR_OUTPUT);
  assign ch2_output_drive_enable = enable[ENABLE_STRIDE + ENABLE_ON]
    & (mode[MODE_STRIDE + MODE_DIR +: 2] == DIR_OUTPUT);

endmodule : timer_capture_compare

// ### sim/timer_capture_compare_properties.sv
/* port checker for the two-channel timer, bound below.
   assumes the register map and enable mask of timer_pkg. */
module timer_cc_checker
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic ch1_output,
  input wire logic ch2_output,
  input wire logic ch1_output_drive_enable,
  input wire logic ch2_output_drive_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] en_q, rel_q, next_en_q, next_rel_q;
  logic acc, rd, known;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign known = paddr inside {OFF_CONTROL, OFF_STATUS, OFF_MODE, OFF_ENABLE, OFF_COUNT,
    OFF_DIVIDER, OFF_RELOAD, OFF_CMP1, OFF_CMP2};
  // shadows move only on a completed write, like the slave
  always_comb
  begin
    next_en_q = en_q;
    next_rel_q = rel_q;
    if (acc && pwrite && paddr == OFF_ENABLE)
      next_en_q = pwdata[15:0] & ENABLE_MASK;
    if (acc && pwrite && paddr == OFF_RELOAD)
      next_rel_q = pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= RESET_VALUE;
      rel_q <= RESET_VALUE;
    end
    else
    begin
      en_q <= next_en_q;
      rel_q <= next_rel_q;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  drive_gate_one_a: assert property (!en_q[0] |-> !ch1_output_drive_enable)
    else $error("drive one on while channel off");
  drive_gate_two_a: assert property (!en_q[4] |-> !ch2_output_drive_enable)
    else $error("drive two on while channel off");
  quiet_one_a: assert property (!en_q[0] && !$past(en_q[0]) |-> !ch1_output)
    else $error("output one high while off");
  quiet_two_a: assert property ((!en_q[4]) [*2] |-> !ch2_output)
    else $error("output two high while off");
  enable_read_a: assert property (rd && paddr == OFF_ENABLE |-> prdata[15:0] == en_q)
    else $error("enable register readback wrong");
  reload_read_a: assert property (rd && paddr == OFF_RELOAD |-> prdata[15:0] == rel_q)
    else $error("reload readback wrong");
  bad_addr_a: assert property (acc && !known |-> pslverr && (pwrite || !prdata))
    else $error("unmapped access not refused");
  err_scope_a: assert property (pslverr |-> acc && !known)
    else $error("error outside unmapped access");
  upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  cover property (rd && paddr == OFF_CMP1);
  cover property (ch1_output_drive_enable && ch1_output);
  cover property (acc && !known);
endmodule : timer_cc_checker

bind timer_capture_compare timer_cc_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .ch1_output(ch1_output), .ch2_output(ch2_output),
  .ch1_output_drive_enable(ch1_output_drive_enable),
  .ch2_output_drive_enable(ch2_output_drive_enable));

// ### sim/timer_pins_model.sv
/* model of the timer pins and the internal trigger line.
   assumes the bench calls drive from its main sequence. */
module timer_pins_model
(
  input wire logic pclk,
  output logic timer_input_one,
  output logic timer_input_two,
  output logic internal_trigger_source
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] lvl = 3'h0;
  assign {internal_trigger_source, timer_input_two, timer_input_one} = lvl;
  // levels move just after an edge, so sync stage timing stays exact
  task automatic drive(input int p, input logic v);
    @(posedge pclk);
    lvl[p] <= v;
  endtask : drive
endmodule : timer_pins_model

// ### sim/tb_two_channel_timer_capture_compare.sv
/* self-checking bench for the two-channel timer.
   assumes the pin model and the bound checker. */
module tb_two_channel_timer_capture_compare
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pin1, pin2, trig, o1, o2, oe1, oe2, s;
  logic [15:0] v;
  logic [7:0] map [6] = '{OFF_ENABLE, OFF_COUNT, OFF_DIVIDER, OFF_RELOAD, OFF_CMP1, OFF_CMP2};
  int pols [3] = '{0, 1, 3}; // pair 10 never programmed
  int rt [4][3] = '{'{0, 2, 1}, '{0, 3, 2}, '{1, 1, 1}, '{1, 2, 0}};
  int fm [3] = '{32'h64, 32'h60, 32'h14};
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, r, c;
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  timer_capture_compare i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_one(pin1), .timer_input_two(pin2),
    .internal_trigger_source(trig), .ch1_output(o1), .ch2_output(o2),
    .ch1_output_drive_enable(oe1), .ch2_output_drive_enable(oe2));
  timer_pins_model i_pins (.pclk(pclk), .timer_input_one(pin1), .timer_input_two(pin2),
    .internal_trigger_source(trig));
  task automatic close_out();
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      close_out();
    end
  end
  function automatic int caps(int pol, int dv, int e);
    return ((pol == 3) ? e : e / 2) >> dv;
  endfunction : caps
  function automatic int duty(int m, int c, int r, int p);
    int a;
    a = (m == 6) ? c : (m == 7) ? r + 1 - c : (m == 5) ? r + 1 : 0;
    return p ? r + 1 - a : a;
  endfunction : duty
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // channel off first: direction only moves while disabled
  task automatic cfg(input int ch, input int md, input int pol, input int en);
    wr(OFF_ENABLE, 32'h0);
    wr(OFF_MODE, 32'(md << (8 * ch)));
    wr(OFF_ENABLE, 32'(((pol / 2) * 8 + (pol % 2) * 2 + en) << (4 * ch)));
  endtask : cfg
  task automatic edges(input logic [7:0] a, input int pin, input int e, output int cnt);
    logic [31:0] old;
    cnt = 0;
    xfer(1'h0, a, 32'h0);
    old = rd;
    for (int k = 0; k < e; k++)
    begin
      i_pins.drive(pin, k % 2 == 0);
      repeat (20) @(posedge pclk);
      xfer(1'h0, a, 32'h0);
      cnt += (rd != old);
      old = rd;
    end
  endtask : edges
  // two counter reads whose setups are 8 clocks apart
  task automatic delta(output logic [15:0] d);
    logic [15:0] first;
    xfer(1'h0, OFF_COUNT, 32'h0);
    first = rd[15:0];
    repeat (5) @(posedge pclk);
    xfer(1'h0, OFF_COUNT, 32'h0);
    d = rd[15:0] - first;
  endtask : delta
  initial
  begin
    void'($urandom(32'h171B));
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    foreach (map[i])
      rdc(map[i], 32'h0);
    xfer(1'h1, 8'h1C, $urandom);
    chk(32'(err), 32'h1);
    rdc(8'h1C, 32'h0);
    for (int i = 2; i < 6; i++)
    begin
      v = 16'($urandom);
      wr(map[i], {16'h0, v});
      rdc(map[i], {16'h0, v});
    end
    v = 16'($urandom) & 16'h0033; // complement bits clear on outputs
    wr(OFF_ENABLE, {16'h0, v});
    rdc(OFF_ENABLE, {16'h0, v});
    wr(OFF_CONTROL, 32'h4);
    for (int ch = 0; ch < 2; ch++)
      for (int d = 0; d < 4; d++)
      begin
        cfg(ch, d, 0, 0);
        rdc(OFF_MODE, 32'(d << (8 * ch)));
        wr(OFF_ENABLE, 32'(1 << (4 * ch)));
        wr(OFF_MODE, 32'((3 - d) << (8 * ch)));
        rdc(OFF_MODE, 32'(d << (8 * ch)));
      end
    cfg(1, 0, 0, 0);
    wr(OFF_RELOAD, 32'h0);
    wr(OFF_COUNT, 32'h1234);
    wr(OFF_CONTROL, 32'h5);
    delta(v);
    chk({16'h0, v}, 32'h0);
    chk(rd, 32'h1234);
    wr(OFF_RELOAD, 32'hFFFF);
    wr(OFF_DIVIDER, 32'h0);
    delta(v);
    chk({16'h0, v}, 32'h8);
    wr(OFF_DIVIDER, 32'h3);
    delta(v);
    chk({16'h0, v}, 32'h8);
    wr(OFF_CONTROL, 32'h7);
    delta(v);
    chk({16'h0, v}, 32'h2);
    wr(OFF_DIVIDER, 32'h0);
    wr(OFF_CONTROL, 32'h7);
    foreach (pols[p])
      for (int dv = 0; dv < 4; dv++)
      begin
        cfg(0, 1 + 4 * dv, pols[p], 1);
        edges(OFF_CMP1, 0, 16, n);
        chk(32'(n), 32'(caps(pols[p], dv, 16)));
      end
    cfg(0, 1, 0, 0);
    edges(OFF_CMP1, 0, 4, n);
    chk(32'(n), 32'h0);
    for (int f = 1; f < 4; f++)
    begin
      cfg(0, 1 + 16 * f, 0, 1);
      xfer(1'h0, OFF_CMP1, 32'h0);
      s = rd[0];
      v = rd[15:0];
      i_pins.drive(0, 1'h1);
      repeat ((1 << f) - 2) @(posedge pclk);
      i_pins.drive(0, 1'h0);
      repeat (30) @(posedge pclk);
      rdc(OFF_CMP1, {16'h0, v});
      edges(OFF_CMP1, 0, 2, n);
      chk(32'(n), 32'h1);
    end
    foreach (rt[i])
    begin
      cfg(rt[i][0], rt[i][1], 0, 1);
      edges(rt[i][0] ? OFF_CMP2 : OFF_CMP1, rt[i][2], 4, n);
      chk(32'(n), 32'h2);
    end
    r = 16 + $urandom_range(15);
    c = $urandom_range(r, 1);
    wr(OFF_RELOAD, 32'(r));
    wr(OFF_CMP1, 32'(c));
    wr(OFF_CONTROL, 32'h7);
    for (int m = 4; m < 8; m++)
      for (int p = 0; p < 2; p++)
      begin
        cfg(0, m << 4, p, 1);
        repeat (4) @(posedge pclk);
        n = 0;
        repeat (4 * (r + 1))
        begin
          @(posedge pclk);
          n += (o1 === 1'h1);
        end
        chk(32'(n), 32'(4 * duty(m, c, r, p)));
        chk(32'(oe1), 32'h1);
      end
    wr(OFF_RELOAD, 32'hFFFF);
    wr(OFF_CMP1, 32'hFFF0);
    foreach (fm[k])
    begin
      wr(OFF_CONTROL, 32'h7);
      cfg(0, fm[k], 0, 1);
      repeat (4) @(posedge pclk);
      // pwm1 sits below compare here, and set mode keeps that level
      s = 1'h1;
      i_pins.drive(2, 1'h1);
      repeat (3) @(posedge pclk);
      chk(32'(o1), 32'(s));
      @(posedge pclk);
      chk(32'(o1), 32'(k == 0 ? 1'h0 : s));
      i_pins.drive(2, 1'h0);
    end
    // preload holds the active compare until the next update
    wr(OFF_CMP2, 32'hFFF0);
    cfg(1, 32'h68, 0, 1);
    wr(OFF_CMP2, 32'h0);
    repeat (4) @(posedge pclk);
    chk(32'(o2), 32'h1);
    wr(OFF_CONTROL, 32'h7);
    repeat (4) @(posedge pclk);
    chk(32'(o2), 32'h0);
    chk(32'(oe2), 32'h1);
    // trigger reset mode: counter cleared, output follows five clocks on
    cfg(0, 32'h60, 0, 1);
    wr(OFF_CMP1, 32'h10);
    wr(OFF_CONTROL, 32'hD);
    repeat (20) @(posedge pclk);
    i_pins.drive(2, 1'h1);
    repeat (5) @(posedge pclk);
    chk(32'(o1), 32'h0);
    @(posedge pclk);
    chk(32'(o1), 32'h1);
    close_out();
  end
endmodule : tb_two_channel_timer_capture_compare
